/* rtl/bp_defines.vh */
// constants for the block transmission protocol framer
`ifndef BP_DEFINES_VH
`define BP_DEFINES_VH
// pcb fields (bit n of the printed layout is index n-1)
`define BP_PCB_BLKNUM 0
`define BP_PCB_FIX2 1
`define BP_PCB_NAD 2
`define BP_PCB_CID 3
`define BP_PCB_CHAIN 4
`define BP_PCB_ACK 4
`define BP_PCB_I_MASK 8'hE2
`define BP_PCB_I_VAL 8'h02
`define BP_PCB_R_MASK 8'hE6
`define BP_PCB_R_VAL 8'hA2
`define BP_PCB_S_MASK 8'hC7
`define BP_PCB_S_VAL 8'hC2
`define BP_S_DESELECT 2'b00
`define BP_CID_PWR_MASK 8'hC0
// response indicators and error codes
`define BP_IND_OK 8'h00
`define BP_IND_ERR 8'h01
`define BP_ERR_BLKNUM 8'h10
`define BP_ERR_LOCKED 8'h11
`define BP_ERR_WRLOCK 8'h12
// crc
`define BP_CRC_INIT 16'hFFFF
`define BP_CRC_POLY 16'h8408
// frame sizes
`define BP_MAXLEN 6'd32
`define BP_MAXLEN_W 6
`define BP_MIN_FRAME 6'd3
`endif

/* rtl/bp_skid.v */
// two-entry buffer in the response byte path
`timescale 1ns/1ps
module bp_skid (
	input wire clk_i,
	input wire rst_i,
	input wire [8:0] in_data_i,
	input wire in_valid_i,
	output wire in_ready_o,
	output wire [8:0] out_data_o,
	output wire out_valid_o,
	input wire out_ready_i
);
	reg [8:0] mem_reg [0:1];
	reg wr_ptr_reg;
	reg rd_ptr_reg;
	reg [1:0] cnt_reg;
	wire push;
	wire pop;

	assign in_ready_o = (cnt_reg != 2'd2);
	assign out_valid_o = (cnt_reg != 2'd0);
	assign out_data_o = mem_reg[rd_ptr_reg];
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;

	// pointers and fill count; data array needs no reset
	always @(posedge clk_i) begin
		if (rst_i) begin
			wr_ptr_reg <= 1'b0;
			rd_ptr_reg <= 1'b0;
			cnt_reg <= 2'd0;
		end else begin
			if (push) begin
				wr_ptr_reg <= ~wr_ptr_reg;
			end
			if (pop) begin
				rd_ptr_reg <= ~rd_ptr_reg;
			end
			if (push & ~pop) begin
				cnt_reg <= cnt_reg + 2'd1;
			end else if (pop & ~push) begin
				cnt_reg <= cnt_reg - 2'd1;
			end
		end
	end

	always @(posedge clk_i) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data_i;
		end
	end
endmodule // bp_skid

/* rtl/bp_block_framer.v */
// block transmission protocol framer: decode requests, build responses
`timescale 1ns/1ps
`include "bp_defines.vh"
module bp_block_framer (
	input wire CLK_SYS_I,
	input wire SYS_RST_I,
	// received frame bytes, crc included
	input wire [7:0] RX_DATA_I,
	input wire RX_VALID_I,
	input wire RX_EOF_I,
	// state control from the network layer
	input wire ACTIVATE_I,
	input wire [3:0] CID_I,
	// command interface to the memory engine
	output reg CMD_VALID_O,
	output reg [7:0] CMD_CODE_O,
	output reg [7:0] CMD_PARAM0_O,
	output reg [5:0] CMD_LEN_O,
	input wire CMD_KNOWN_I,
	input wire CMD_DONE_I,
	input wire CMD_ERR_I,
	input wire [7:0] CMD_ERR_CODE_I,
	input wire [7:0] RSP_DATA_I,
	input wire RSP_VALID_I,
	input wire RSP_LAST_I,
	output reg RSP_READY_O,
	// transmit byte stream, crc appended
	output reg [7:0] TX_DATA_O,
	output reg TX_VALID_O,
	output reg TX_LAST_O,
	input wire TX_READY_I,
	output reg ACTIVE_O,
	output reg DESELECT_O
);
	// ***********************************************************
	// state encoding
	// ***********************************************************
	localparam ST_IDLE = 6'b000001;
	localparam ST_CMD = 6'b000010;
	localparam ST_HDR = 6'b000100;
	localparam ST_BODY = 6'b001000;
	localparam ST_CRCL = 6'b010000;
	localparam ST_CRCH = 6'b100000;

	reg [5:0] state_reg;
	reg [5:0] state_next;
	reg [7:0] rx_buf [0:31];
	reg [5:0] rx_cnt_reg;
	reg [15:0] rx_crc_reg;
	reg [15:0] tx_crc_reg;
	reg blk_num_reg;
	reg rsp_cid_reg;
	reg [7:0] last_rsp [0:31];
	reg [5:0] last_len_reg;
	reg have_last_reg;
	reg [5:0] hdr_idx_reg;
	reg replay_reg;
	reg err_reg;
	reg [7:0] err_code_reg;
	reg [5:0] wr_len_reg;

	// crc-16-ccitt, reflected, one byte
	function [15:0] crc_byte;
		input [15:0] crc;
		input [7:0] data;
		integer k;
		reg [15:0] c;
		begin
			c = crc ^ {8'h00, data};
			for (k = 0; k < 8; k = k + 1) begin
				c = c[0] ? ((c >> 1) ^ `BP_CRC_POLY) : (c >> 1);
			end
			crc_byte = c;
		end
	endfunction

	// pcb class check, used by the frame decode
	function pcb_is;
		input [7:0] pcb;
		input [7:0] mask;
		input [7:0] val;
		begin
			pcb_is = ((pcb & mask) == val);
		end
	endfunction

	// ***********************************************************
	// receive side
	// ***********************************************************
	wire [7:0] pcb = rx_buf[0];
	wire [7:0] cid_byte = rx_buf[1];
	wire has_cid = pcb[`BP_PCB_CID];
	wire is_i = pcb_is(pcb, `BP_PCB_I_MASK, `BP_PCB_I_VAL);
	wire is_r = pcb_is(pcb, `BP_PCB_R_MASK, `BP_PCB_R_VAL);
	wire is_s = pcb_is(pcb, `BP_PCB_S_MASK, `BP_PCB_S_VAL);
	// crc residue of an intact frame including its inverted crc
	wire crc_ok = (rx_crc_reg == 16'hF0B8);
	// cid byte must name us with zero power bits; no cid needs id zero
	wire cid_ok = has_cid ?
		(((cid_byte & `BP_CID_PWR_MASK) == 8'h00) &&
		(cid_byte[3:0] == CID_I)) : (CID_I == 4'd0);
	// prologue: pcb then optional cid, nad never accepted
	wire [5:0] pro_len = has_cid ? 6'd2 : 6'd1;
	wire [5:0] info_len = rx_cnt_reg - pro_len - 6'd2;
	wire frame_ok = RX_EOF_I && ACTIVE_O && crc_ok && cid_ok &&
		(rx_cnt_reg >= pro_len + 6'd2) && (state_reg == ST_IDLE);
	wire i_ok = is_i && !pcb[`BP_PCB_CHAIN] && !pcb[`BP_PCB_NAD] &&
		(info_len != 6'd0);
	wire r_nak = is_r && pcb[`BP_PCB_ACK];
	wire s_desel = is_s && (pcb[5:4] == `BP_S_DESELECT);
	// a nak with the same block number asks for the last reply again
	wire do_replay = frame_ok && r_nak && have_last_reg &&
		(pcb[`BP_PCB_BLKNUM] == blk_num_reg);

	// frame capture; frames over 31 bytes are clipped and fail crc
	always @(posedge CLK_SYS_I) begin
		if (SYS_RST_I || RX_EOF_I) begin
			rx_cnt_reg <= 6'd0;
			rx_crc_reg <= `BP_CRC_INIT;
		end else if (RX_VALID_I && rx_cnt_reg != `BP_MAXLEN - 6'd1) begin
			rx_buf[rx_cnt_reg[4:0]] <= RX_DATA_I;
			rx_cnt_reg <= rx_cnt_reg + 6'd1;
			rx_crc_reg <= crc_byte(rx_crc_reg, RX_DATA_I);
		end
	end

	// protocol state: active/halt held here
	always @(posedge CLK_SYS_I) begin
		if (SYS_RST_I) begin
			ACTIVE_O <= 1'b0;
			DESELECT_O <= 1'b0;
		end else begin
			DESELECT_O <= 1'b0;
			if (ACTIVATE_I) begin
				ACTIVE_O <= 1'b1;
			end else if (frame_ok && s_desel) begin
				// no s-block reply is produced here, so no info field
				ACTIVE_O <= 1'b0;
				DESELECT_O <= 1'b1;
			end
		end
	end
	// ***********************************************************
	// response build through the two-entry buffer
	// ***********************************************************
	reg [8:0] bf_in_reg;
	reg bf_valid_reg;
	wire bf_ready;
	wire [8:0] bf_out;
	wire bf_out_valid;
	wire bf_pop = bf_out_valid && (!TX_VALID_O || TX_READY_I);
	wire bf_push = bf_valid_reg && bf_ready;

	bp_skid u_skid (
		.clk_i(CLK_SYS_I),
		.rst_i(SYS_RST_I),
		.in_data_i(bf_in_reg),
		.in_valid_i(bf_valid_reg),
		.in_ready_o(bf_ready),
		.out_data_o(bf_out),
		.out_valid_o(bf_out_valid),
		.out_ready_i(bf_pop)
	);

	// header byte by index: pcb, cid, then indicator and error code
	reg [7:0] hdr_byte;
	wire [7:0] ind_byte = err_reg ? `BP_IND_ERR : `BP_IND_OK;
	always @* begin
		hdr_byte = 8'h00;
		case (hdr_idx_reg)
		6'd0: hdr_byte = {4'h0, rsp_cid_reg, 2'b01, blk_num_reg};
		6'd1: hdr_byte = rsp_cid_reg ? {4'h0, CID_I} : ind_byte;
		6'd2: hdr_byte = rsp_cid_reg ? ind_byte : err_code_reg;
		default: hdr_byte = err_code_reg;
		endcase
	end
	wire [5:0] hdr_len = (rsp_cid_reg ? 6'd3 : 6'd2) +
		(err_reg ? 6'd1 : 6'd0);
	// main sequencer
	always @* begin
		state_next = state_reg;
		case (state_reg)
		ST_IDLE: begin
			if (do_replay) begin
				state_next = ST_BODY;
			end else if (frame_ok && is_i && i_ok && cid_ok) begin
				state_next = ST_CMD;
			end
		end
		ST_CMD: begin
			if (!CMD_KNOWN_I) begin
				state_next = ST_IDLE;
			end else if (CMD_DONE_I) begin
				state_next = ST_HDR;
			end
		end
		ST_HDR: begin
			if (bf_push && hdr_idx_reg == hdr_len - 6'd1) begin
				state_next = err_reg ? ST_CRCL : ST_BODY;
			end
		end
		ST_BODY: begin
			if (replay_reg) begin
				if (bf_push && hdr_idx_reg == last_len_reg - 6'd1) begin
					state_next = ST_CRCL;
				end
			end else if (RSP_VALID_I && RSP_READY_O && RSP_LAST_I) begin
				state_next = ST_CRCL;
			end
		end
		ST_CRCL: begin
			if (bf_push) begin
				state_next = ST_CRCH;
			end
		end
		ST_CRCH: begin
			if (bf_push) begin
				state_next = ST_IDLE;
			end
		end
		default: state_next = ST_IDLE;
		endcase
	end

	// byte to push in the next cycle, crc tracking, reply copy
	always @(posedge CLK_SYS_I) begin
		if (SYS_RST_I) begin
			state_reg <= ST_IDLE;
			bf_valid_reg <= 1'b0;
			bf_in_reg <= 9'h000;
			hdr_idx_reg <= 6'd0;
			tx_crc_reg <= `BP_CRC_INIT;
			blk_num_reg <= 1'b0;
			rsp_cid_reg <= 1'b0;
			have_last_reg <= 1'b0;
			replay_reg <= 1'b0;
			err_reg <= 1'b0;
			err_code_reg <= 8'h00;
			last_len_reg <= 6'd0;
			wr_len_reg <= 6'd0;
			CMD_VALID_O <= 1'b0;
			CMD_CODE_O <= 8'h00;
			CMD_PARAM0_O <= 8'h00;
			CMD_LEN_O <= 6'd0;
			RSP_READY_O <= 1'b0;
		end else begin
			state_reg <= state_next;
			CMD_VALID_O <= 1'b0;
			RSP_READY_O <= 1'b0;
			if (bf_push) begin
				bf_valid_reg <= 1'b0;
			end
			case (state_reg)
			ST_IDLE: begin
				hdr_idx_reg <= 6'd0;
				tx_crc_reg <= `BP_CRC_INIT;
				if (do_replay) begin
					replay_reg <= 1'b1;
				end else if (state_next == ST_CMD) begin
					replay_reg <= 1'b0;
					blk_num_reg <= pcb[`BP_PCB_BLKNUM];
					rsp_cid_reg <= has_cid;
					CMD_VALID_O <= 1'b1;
					CMD_CODE_O <= rx_buf[pro_len[4:0]];
					CMD_PARAM0_O <= rx_buf[pro_len[4:0] + 5'd1];
					CMD_LEN_O <= info_len;
				end
			end
			ST_CMD: begin
				err_reg <= CMD_ERR_I;
				err_code_reg <= CMD_ERR_CODE_I;
				if (!CMD_KNOWN_I) begin
					have_last_reg <= 1'b0;
				end
			end
			ST_HDR: begin
				if (!bf_valid_reg || bf_push) begin
					bf_in_reg <= {1'b0, hdr_byte};
					bf_valid_reg <= 1'b1;
					tx_crc_reg <= crc_byte(tx_crc_reg, hdr_byte);
					last_rsp[hdr_idx_reg[4:0]] <= hdr_byte;
					hdr_idx_reg <= hdr_idx_reg + 6'd1;
					wr_len_reg <= hdr_idx_reg + 6'd1;
					if (hdr_idx_reg == hdr_len - 6'd1) begin
						hdr_idx_reg <= 6'd0;
					end
				end
			end
			ST_BODY: begin
				if (replay_reg) begin
					if (!bf_valid_reg || bf_push) begin
						bf_in_reg <= {1'b0, last_rsp[hdr_idx_reg[4:0]]};
						bf_valid_reg <= 1'b1;
						tx_crc_reg <= crc_byte(tx_crc_reg,
							last_rsp[hdr_idx_reg[4:0]]);
						hdr_idx_reg <= hdr_idx_reg + 6'd1;
					end
				end else begin
					// stall the memory engine while the buffer is full
					RSP_READY_O <= bf_ready && !bf_valid_reg;
					if (RSP_VALID_I && RSP_READY_O) begin
						bf_in_reg <= {1'b0, RSP_DATA_I};
						bf_valid_reg <= 1'b1;
						RSP_READY_O <= 1'b0;
						tx_crc_reg <= crc_byte(tx_crc_reg, RSP_DATA_I);
						last_rsp[wr_len_reg[4:0]] <= RSP_DATA_I;
						wr_len_reg <= wr_len_reg + 6'd1;
					end
				end
			end
			ST_CRCL: begin
				if (!bf_valid_reg || bf_push) begin
					bf_in_reg <= {1'b0, ~tx_crc_reg[7:0]};
					bf_valid_reg <= 1'b1;
					if (!replay_reg) begin
						last_len_reg <= wr_len_reg;
						have_last_reg <= 1'b1;
					end
				end
			end
			ST_CRCH: begin
				if (!bf_valid_reg || bf_push) begin
					bf_in_reg <= {1'b1, ~tx_crc_reg[15:8]};
					bf_valid_reg <= 1'b1;
				end
			end
			default: bf_valid_reg <= 1'b0;
			endcase
		end
	end

	// transmit output register; bit 8 of a buffer word marks the last byte
	always @(posedge CLK_SYS_I) begin
		if (SYS_RST_I) begin
			TX_DATA_O <= 8'h00;
			TX_VALID_O <= 1'b0;
			TX_LAST_O <= 1'b0;
		end else if (bf_pop) begin
			TX_DATA_O <= bf_out[7:0];
			TX_VALID_O <= 1'b1;
			TX_LAST_O <= bf_out[8];
		end else if (TX_READY_I) begin
			TX_VALID_O <= 1'b0;
			TX_LAST_O <= 1'b0;
		end
	end
endmodule // bp_block_framer

/* testbench/bp_block_framer_props.sv */
// concurrent checks on the block framer ports
`timescale 1ns/1ps
// ****************
// port checker
// ****************
module bp_block_framer_props (
	input wire CLK_SYS_I,
	input wire SYS_RST_I,
	input wire RX_EOF_I,
	input wire ACTIVATE_I,
	input wire CMD_VALID_O,
	input wire [5:0] CMD_LEN_O,
	input wire [7:0] TX_DATA_O,
	input wire TX_VALID_O,
	input wire TX_LAST_O,
	input wire TX_READY_I,
	input wire ACTIVE_O,
	input wire DESELECT_O
);
	reg mid_reg;
	// high once the pcb of a reply has gone out
	always @(posedge CLK_SYS_I) begin
		if (SYS_RST_I)
			mid_reg <= 1'b0;
		else if (TX_VALID_O && TX_READY_I)
			mid_reg <= !TX_LAST_O;
	end
	default clocking @(posedge CLK_SYS_I); endclocking
	default disable iff (SYS_RST_I);
	sequence s_stall;
		TX_VALID_O && !TX_READY_I;
	endsequence
	sequence s_held;
		TX_VALID_O && $stable(TX_DATA_O) && $stable(TX_LAST_O);
	endsequence
	chk_tx_hold: assert property (s_stall |=> s_held)
		else $error("tx byte changed while stalled");
	chk_reply_pcb: assert property (
		TX_VALID_O && !mid_reg |-> (TX_DATA_O & 8'hF6) == 8'h02)
		else $error("reply does not open with an i-block pcb");
	chk_last_mid: assert property (TX_VALID_O && TX_LAST_O |-> mid_reg)
		else $error("reply ends on its first byte");
	chk_cmd_pulse: assert property (CMD_VALID_O |=> !CMD_VALID_O)
		else $error("command strobe longer than one cycle");
	chk_cmd_cause: assert property (
		CMD_VALID_O |-> $past(RX_EOF_I) && $past(ACTIVE_O))
		else $error("command without frame end while active");
	chk_cmd_len: assert property (
		CMD_VALID_O |-> CMD_LEN_O inside {[6'd1:6'd28]})
		else $error("info length out of range");
	chk_act_up: assert property (ACTIVATE_I |=> ACTIVE_O)
		else $error("activation not taken");
	chk_desel_halt: assert property (
		DESELECT_O |=> (!ACTIVE_O && !TX_VALID_O) [*2])
		else $error("still active after deselect");
	chk_tx_active: assert property ($rose(TX_VALID_O) |-> ACTIVE_O)
		else $error("reply while not active");
	chk_reset_quiet: assert property ($fell(SYS_RST_I) |->
		!ACTIVE_O && !TX_VALID_O && !CMD_VALID_O)
		else $error("outputs busy after reset");
endmodule // bp_block_framer_props

bind bp_block_framer bp_block_framer_props chk_u (.CLK_SYS_I, .SYS_RST_I,
	.RX_EOF_I, .ACTIVATE_I, .CMD_VALID_O, .CMD_LEN_O, .TX_DATA_O,
	.TX_VALID_O, .TX_LAST_O, .TX_READY_I, .ACTIVE_O, .DESELECT_O);

/* testbench/bp_reader_model.sv */
// reader model: sends request frames and takes reply bytes
`timescale 1ns/1ps
// ****************
// reader
// ****************
module bp_reader_model (
	input wire clk_i,
	output logic [7:0] rx_data_o,
	output logic rx_valid_o,
	output logic rx_eof_o,
	input wire [7:0] tx_data_i,
	input wire tx_valid_i,
	input wire tx_last_i,
	output logic tx_ready_o
);
	logic [7:0] got[$];
	int frames = 0;
	bit stall = 1'b0;
	// inverted reflected crc over all bytes given
	function automatic [15:0] crc(input logic [7:0] q[$]);
		logic [15:0] c;
		c = 16'hFFFF;
		foreach (q[i]) begin
			c = c ^ {8'h00, q[i]};
			repeat (8) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
		end
		return ~c;
	endfunction
	// one byte every other cycle; released data line shows its inverse
	task automatic send(input logic [7:0] q[$], input bit bad);
		logic [15:0] c;
		c = crc(q) ^ {15'h0000, bad};
		q.push_back(c[7:0]);
		q.push_back(c[15:8]);
		foreach (q[i]) begin
			@(negedge clk_i);
			rx_data_o = q[i];
			rx_valid_o = 1'b1;
			@(negedge clk_i);
			rx_valid_o = 1'b0;
			rx_data_o = ~q[i];
		end
		rx_eof_o = 1'b1;
		@(negedge clk_i);
		rx_eof_o = 1'b0;
	endtask
	initial begin
		rx_data_o = 8'h00;
		rx_valid_o = 1'b0;
		rx_eof_o = 1'b0;
		tx_ready_o = 1'b0;
	end
	// stall every other cycle on request, so held bytes get exercised
	always @(negedge clk_i) tx_ready_o <= stall ? ~tx_ready_o : 1'b1;
	// collect reply bytes, count finished replies
	always @(posedge clk_i) begin
		if (tx_valid_i && tx_ready_o) begin
			got.push_back(tx_data_i);
			if (tx_last_i)
				frames++;
		end
	end
endmodule // bp_reader_model

/* testbench/bp_block_framer_tb.sv */
// self-checking bench for the block framer
`timescale 1ns/1ps
// ****************
// bench top
// ****************
module bp_block_framer_tb;
	logic clk = 1'b0, rst = 1'b1, act = 1'b0, known = 1'b1;
	logic done = 1'b0, err = 1'b0, rsp_valid = 1'b0, rsp_last = 1'b0;
	logic [3:0] cid = 4'h5;
	logic [7:0] err_code = 8'h00, rsp_data = 8'h00, cmd_code, cmd_p0;
	logic [7:0] rx_data, tx_data;
	logic [5:0] cmd_len;
	logic rx_valid, rx_eof, cmd_valid, rsp_ready, tx_valid, tx_last;
	logic tx_ready, active, desel;
	int num_errors = 0, total_checks = 0;
	bit seen;
	always #10 clk = ~clk;
	bp_block_framer dut_u (.CLK_SYS_I(clk), .SYS_RST_I(rst),
		.RX_DATA_I(rx_data), .RX_VALID_I(rx_valid), .RX_EOF_I(rx_eof),
		.ACTIVATE_I(act), .CID_I(cid), .CMD_VALID_O(cmd_valid),
		.CMD_CODE_O(cmd_code), .CMD_PARAM0_O(cmd_p0), .CMD_LEN_O(cmd_len),
		.CMD_KNOWN_I(known), .CMD_DONE_I(done), .CMD_ERR_I(err),
		.CMD_ERR_CODE_I(err_code), .RSP_DATA_I(rsp_data),
		.RSP_VALID_I(rsp_valid), .RSP_LAST_I(rsp_last),
		.RSP_READY_O(rsp_ready), .TX_DATA_O(tx_data), .TX_VALID_O(tx_valid),
		.TX_LAST_O(tx_last), .TX_READY_I(tx_ready), .ACTIVE_O(active),
		.DESELECT_O(desel));
	bp_reader_model rdr_u (.clk_i(clk), .rx_data_o(rx_data),
		.rx_valid_o(rx_valid), .rx_eof_o(rx_eof), .tx_data_i(tx_data),
		.tx_valid_i(tx_valid), .tx_last_i(tx_last), .tx_ready_o(tx_ready));
	task automatic check(input bit ok, input string m);
		total_checks++;
		if (!ok) begin
			num_errors++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	task automatic results;
		$display("errors %0d checks %0d", num_errors, total_checks);
		if (num_errors == 0 && total_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic activate;
		@(negedge clk);
		act = 1'b1;
		@(negedge clk);
		act = 1'b0;
	endtask
	// memory engine side: wait for a command, finish it, stream data
	task automatic serve(input bit e, input logic [7:0] ec, input int nd);
		int i, k;
		seen = 1'b0;
		// the strobe may already stand when the frame sender returns
		for (k = 0; k < 40 && !seen; k++) begin
			seen = (cmd_valid === 1'b1);
			if (!seen) @(negedge clk);
		end
		if (seen && known) begin
			done = 1'b1;
			err = e;
			err_code = ec;
			@(negedge clk);
			done = 1'b0;
			for (i = 0; i < nd; i++) begin
				rsp_data = 8'hA0 + i[7:0];
				rsp_valid = 1'b1;
				rsp_last = (i == nd - 1);
				for (k = 0; k < 50 && rsp_ready !== 1'b1; k++) @(negedge clk);
				check(k < 50, "response byte never taken");
				@(negedge clk);
			end
			rsp_valid = 1'b0;
			rsp_last = 1'b0;
		end
	endtask
	// wait for one whole reply and compare it, crc included
	task automatic reply(input logic [7:0] e[$]);
		logic [15:0] c;
		int k;
		bit ok;
		c = rdr_u.crc(e);
		e.push_back(c[7:0]);
		e.push_back(c[15:8]);
		for (k = 0; k < 400 && rdr_u.frames == 0; k++) @(negedge clk);
		ok = (rdr_u.frames == 1) && (rdr_u.got.size() == e.size());
		foreach (e[i]) ok &= (rdr_u.got[i] === e[i]);
		check(ok, "reply bytes differ");
		rdr_u.got.delete();
		rdr_u.frames = 0;
	endtask
	task automatic quiet(input bit cmd_seen);
		repeat (60) @(negedge clk);
		check(seen == cmd_seen && rdr_u.got.size() == 0, "unexpected reply");
	endtask
	// cid request with stalled reader, then nak replay and ignored ack
	task automatic t_cid_ok;
		activate();
		rdr_u.stall = 1'b1;
		rdr_u.send('{8'h0B, 8'h05, 8'h20, 8'h07}, 1'b0);
		serve(1'b0, 8'h00, 2);
		check(cmd_code === 8'h20 && cmd_p0 === 8'h07, "command");
		check(cmd_len === 6'd2, "info length");
		reply('{8'h0B, 8'h05, 8'h00, 8'hA0, 8'hA1});
		rdr_u.send('{8'hBB, 8'h05}, 1'b0);
		reply('{8'h0B, 8'h05, 8'h00, 8'hA0, 8'hA1});
		rdr_u.stall = 1'b0;
		rdr_u.send('{8'hAB, 8'h05}, 1'b0);
		seen = 1'b0;
		quiet(1'b0);
	endtask
	// every error code, alternating block numbers
	task automatic t_errs;
		logic [7:0] p;
		for (int i = 0; i < 3; i++) begin
			p = 8'h0A | i[7:0] & 8'h01;
			rdr_u.send('{p, 8'h05, 8'h22, 8'h03}, 1'b0);
			serve(1'b1, 8'h10 + i[7:0], 0);
			reply('{p, 8'h05, 8'h01, 8'h10 + i[7:0]});
		end
	endtask
	task automatic drop(input logic [7:0] q[$], input bit bad);
		rdr_u.send(q, bad);
		serve(1'b0, 8'h00, 1);
		quiet(1'b0);
	endtask
	// frames that must be ignored
	task automatic t_drop;
		drop('{8'h1A, 8'h05, 8'h20, 8'h00}, 1'b0);
		drop('{8'h0E, 8'h05, 8'h20, 8'h00}, 1'b0);
		drop('{8'h0A, 8'h06, 8'h20, 8'h00}, 1'b0);
		drop('{8'h02, 8'h20, 8'h00}, 1'b0);
		drop('{8'h4A, 8'h05, 8'h20, 8'h00}, 1'b0);
		drop('{8'h0A, 8'h05, 8'h20, 8'h00}, 1'b1);
		drop('{8'h0A, 8'h05}, 1'b0);
	endtask
	task automatic t_unknown;
		known = 1'b0;
		rdr_u.send('{8'h0B, 8'h05, 8'h55}, 1'b0);
		serve(1'b0, 8'h00, 1);
		quiet(1'b1);
		known = 1'b1;
	endtask
	// deselect, refusal while halted, then no-cid use with id zero
	task automatic t_desel;
		rdr_u.send('{8'hCA, 8'h05}, 1'b0);
		check(desel === 1'b1, "no deselect pulse");
		seen = 1'b0;
		quiet(1'b0);
		check(active === 1'b0, "still active");
		drop('{8'h0A, 8'h05, 8'h20, 8'h00}, 1'b0);
		cid = 4'h0;
		activate();
		rdr_u.send('{8'h03, 8'h30}, 1'b0);
		serve(1'b0, 8'h00, 1);
		reply('{8'h03, 8'h00, 8'hA0});
	endtask
	initial begin
		repeat (3) @(negedge clk);
		rst = 1'b0;
		t_cid_ok();
		t_errs();
		t_drop();
		t_unknown();
		t_desel();
		results();
	end
	initial begin
		#1000000;
		num_errors++;
		results();
	end
endmodule // bp_block_framer_tb
